// ---- include/cis_cfg.svh ----
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH
// Register byte offsets on the Avalon-MM slave.
`define CIS_OFF_MODE2 6'h00
`define CIS_OFF_VERT 6'h04
`define CIS_OFF_SCROLL 6'h08
`define CIS_OFF_TOP_SOFT 6'h0C
`define CIS_OFF_TOP_HARD 6'h10
`define CIS_OFF_VECTOR 6'h14
`define CIS_OFF_EVENT 6'h18
`define CIS_OFF_STATUS 6'h1C
// Mode register 2 field positions.
`define CIS_M2_SCR_PEND 0
`define CIS_M2_SCR_EN 1
`define CIS_M2_SCR_INSVC 2
`define CIS_M2_VRT_PEND 3
`define CIS_M2_VRT_EN 4
`define CIS_M2_VRT_INSVC 5
`define CIS_M2_BLOCK_LOWER 6
`define CIS_M2_NO_VECTOR 7
`define CIS_M2_SCROLL_ACTIVE 8
// Scroll control field positions.
`define CIS_SC_ON 0
`define CIS_SC_WINDOW 1
`define CIS_SC_DOWN 2
`define CIS_SC_OFFSET_LSB 3
`define CIS_SC_WSEL_LSB 8
// Event register: pulses written by the row and scroll sequencers.
`define CIS_EV_ROW_LOADED 0
`define CIS_EV_ROW_DONE 1
`define CIS_EV_ROW_START 2
`define CIS_EV_FRAME_START 3
// Vector bit that carries the scroll-active status.
`define CIS_VEC_SCROLL_BIT 1
// Reset values.
`define CIS_RST_VECTOR 8'h00
`define CIS_RST_TOP 16'h0000
`define CIS_RST_ROWCNT 8'h01
`endif

// ---- include/cis_pkg.sv ----
package cis_pkg;
  // Per-source interrupt control bits.
  typedef struct packed {
    logic pending;
    logic enable;
    logic in_service;
  } cis_src_t;
  // Acknowledge bus from the host processor.
  typedef struct packed {
    logic ack;
    logic strobe;
  } cis_ack_t;
  // Address/data pins as two signals each.
  typedef struct packed {
    logic [15:0] dout;
    logic [15:0] oe_n;
  } cis_ad_t;
  // Bus slave states.
  typedef enum logic [0:0] {CIS_IDLE, CIS_DONE} cis_bus_t;
endpackage : cis_pkg

// ---- logic/cis_irq.sv ----
`timescale 1ns/1ps
`include "cis_cfg.svh"
// Notes on behaviour
// - Vertical irq after n-th row loaded.
// - Count one fires after first row's final segment.
// - Scroll source outranks vertical source.
// - Each source has pending, enable, in-service.
// - Request only when pending, enabled, idle, chain high.
// - Enabled pending source holds chain out low during acknowledge.
// - Falling strobe sets in-service of winning source.
// - Vector on low byte, upper byte low.
// - No-vector flag floats all sixteen pins.
// - In-service forces chain out low when enabled.
// - Disabled source still latches pending.
// - Clearing enable releases the request line.
// - Disabled source ignores acknowledge, chain passes.
// - Block-lower flag forces chain out low.
// - Scroll windows or background, never both.
// - Row line address is line count plus offset where scrolled.
// - Scroll irq when new row scroll begins.
// - Shadow top pointer moves in at row completion.
// - Shadow inert when not scrolling; direct immediate.
// - Scroll-on, window select and direction flags.
// - Only selected windows scroll together.
// - Scroll-active status in vector bit 1.
// - Scroll enable at mode-2 bit 1.
// - Scroll in-service at mode-2 bit 2.

////////////////////////////////////////////////////////////////////////////////

module cis_irq #(
  parameter int WIN_COUNT = 8 // Number of windows with a scroll-select bit.
) (
  input wire logic clk, // 20 MHz controller clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [5:0] avs_address, // Byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Stall until answer ready.
  input wire logic priority_chain_in, // Chain input pin, high lets us request.
  output logic priority_chain_out, // Chain output pin.
  output logic irq_request_n, // Request line, active low.
  input wire logic irq_acknowledge_strobe_n, // Acknowledge pin, active low.
  input wire logic data_strobe_n, // Data strobe pin, active low.
  output logic [15:0] ad_out, // Address/data drive value.
  output logic [15:0] ad_oe_n, // Address/data enables, low drives.
  input wire logic [4:0] row_line_count, // Scan line within the current row.
  input wire logic in_window, // Current character lies in a window.
  input wire logic [2:0] window_index, // Window being displayed.
  output logic [4:0] row_line_address, // Row line address outputs.
  output logic [15:0] active_top // Top pointer used for fetching.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [2:0] pin_s1_reg; // First stage, read only by the second stage.
  logic [2:0] pin_s2_reg; // Second stage, used by logic.
  logic strobe_d_reg; // Previous strobe level for edge detection.
  logic chain_in; // Synchronised chain input.
  logic ack_on; // Acknowledge cycle in progress.
  logic strobe_on; // Data strobe asserted.
  logic strobe_fall; // Falling data strobe.

  // Pins arrive from outside; two flops before any logic looks at them.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_reg <= 3'h7;
      pin_s2_reg <= 3'h7;
      strobe_d_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {priority_chain_in, irq_acknowledge_strobe_n, data_strobe_n};
      pin_s2_reg <= pin_s1_reg;
      strobe_d_reg <= strobe_on;
    end
  end

  assign chain_in = pin_s2_reg[2];
  assign ack_on = !pin_s2_reg[1];
  assign strobe_on = !pin_s2_reg[0];
  assign strobe_fall = strobe_on && !strobe_d_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.

  cis_pkg::cis_src_t scr_reg; // Scroll source, higher priority.
  cis_pkg::cis_src_t vrt_reg; // Vertical source.
  logic block_lower_chain_reg; // Forces chain out low.
  logic no_vector_flag_reg; // Leaves vector to outside circuitry.
  logic [7:0] row_count_irq_field_reg; // Row number that raises the vertical irq.
  logic [7:0] vector_reg; // Base interrupt vector.
  logic smooth_scroll_on_reg; // Scroll-on flag.
  logic scroll_window_reg; // High scrolls windows, low background.
  logic scroll_down_reg; // Scroll direction.
  logic [4:0] scroll_offset_reg; // Scan-line offset applied while scrolling.
  logic [WIN_COUNT-1:0] window_scroll_select_reg; // Per-window scroll select.
  logic [15:0] top_soft_reg; // Shadow top pointer.
  logic [15:0] top_hard_reg; // Active top pointer.
  logic scroll_active_status_reg; // Scroll in progress.
  logic [7:0] rows_loaded_reg; // Rows loaded this frame.
  logic vrt_event; // Vertical event pulse.
  logic scr_event; // Scroll event pulse.
  logic row_done; // Row scroll completed pulse.
  logic frame_start; // Frame restart pulse from software sequencer.
  logic wr_mode2; // Write to mode register 2.
  logic bus_go; // Request taken this cycle.
  logic wr_go; // Write taken this cycle.
  cis_pkg::cis_bus_t bus_state_reg; // Bus slave state.

  assign bus_go = (avs_read || avs_write) && bus_state_reg == cis_pkg::CIS_IDLE;
  assign wr_go = bus_go && avs_write;
  assign wr_mode2 = wr_go && avs_address == `CIS_OFF_MODE2;
  // The sequencers outside this block report progress through the event register.
  assign frame_start = wr_go && avs_address == `CIS_OFF_EVENT
    && avs_writedata[`CIS_EV_FRAME_START];
  assign row_done = wr_go && avs_address == `CIS_OFF_EVENT
    && avs_writedata[`CIS_EV_ROW_DONE] && scroll_active_status_reg;
  // Scroll irq at the start of each new row scroll.
  assign scr_event = wr_go && avs_address == `CIS_OFF_EVENT
    && avs_writedata[`CIS_EV_ROW_START] && scroll_active_status_reg;

  // Vertical event: the n-th completely loaded row, counting from one.
  assign vrt_event = wr_go && avs_address == `CIS_OFF_EVENT
    && avs_writedata[`CIS_EV_ROW_LOADED]
    && (rows_loaded_reg + 8'h01) == row_count_irq_field_reg;

  // Count of rows fully loaded since the frame began.
  always_ff @(posedge clk) begin
    if (!rst_n || frame_start) begin
      rows_loaded_reg <= 8'h00;
    end else if (wr_go && avs_address == `CIS_OFF_EVENT
                 && avs_writedata[`CIS_EV_ROW_LOADED]) begin
      rows_loaded_reg <= rows_loaded_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt sources and daisy chain.

  logic scr_take; // Scroll source is being acknowledged.
  logic vrt_take; // Vertical source is being acknowledged.
  logic scr_out; // Chain between scroll and vertical source.
  logic chain_next; // Next chain output.
  logic req_next; // Next request line level.

  // Scroll source sits first on the chain, the vertical source below it.
  assign scr_take = strobe_fall && ack_on && scr_reg.enable && scr_reg.pending
    && !scr_reg.in_service && chain_in;
  assign vrt_take = strobe_fall && ack_on && vrt_reg.enable && vrt_reg.pending
    && !vrt_reg.in_service && scr_out;

  // Chain output of each source; a disabled source simply passes.
  assign scr_out = chain_in && !(scr_reg.enable && (scr_reg.in_service
    || (ack_on && scr_reg.pending)));
  assign chain_next = !block_lower_chain_reg && scr_out && !(vrt_reg.enable
    && (vrt_reg.in_service || (ack_on && vrt_reg.pending)));

  // Request: pending, enabled, not in service, chain high, no acknowledge.
  assign req_next = !ack_on && ((scr_reg.pending && scr_reg.enable
    && !scr_reg.in_service && chain_in) || (vrt_reg.pending && vrt_reg.enable
    && !vrt_reg.in_service && scr_out));

  // Scroll source bits; the event sets pending even when disabled, set beats clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scr_reg <= '0;
    end else begin
      if (wr_mode2) begin
        scr_reg.enable <= avs_writedata[`CIS_M2_SCR_EN];
      end
      scr_reg.pending <= scr_event
        || (scr_reg.pending && !(wr_mode2 && !avs_writedata[`CIS_M2_SCR_PEND]));
      scr_reg.in_service <= scr_take || (scr_reg.in_service
        && !(wr_mode2 && !avs_writedata[`CIS_M2_SCR_INSVC]));
    end
  end

  // Vertical source bits, same shape as the scroll source.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vrt_reg <= '0;
    end else begin
      if (wr_mode2) begin
        vrt_reg.enable <= avs_writedata[`CIS_M2_VRT_EN];
      end
      vrt_reg.pending <= vrt_event
        || (vrt_reg.pending && !(wr_mode2 && !avs_writedata[`CIS_M2_VRT_PEND]));
      vrt_reg.in_service <= vrt_take || (vrt_reg.in_service
        && !(wr_mode2 && !avs_writedata[`CIS_M2_VRT_INSVC]));
    end
  end

  // Chain and request pins come from flops.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      priority_chain_out <= 1'b0;
      irq_request_n <= 1'b1;
    end else begin
      priority_chain_out <= chain_next;
      irq_request_n <= !req_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Vector drive during acknowledge.

  logic vec_owner_reg; // This device won the acknowledge.

  // The winner keeps the bus through every strobe of the acknowledge cycle.
  always_ff @(posedge clk) begin
    if (!rst_n || !ack_on) begin
      vec_owner_reg <= 1'b0;
    end else if (scr_take || vrt_take) begin
      vec_owner_reg <= 1'b1;
    end
  end

  // Low byte carries the vector with scroll status in bit 1; pins float when told.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ad_out <= 16'h0000;
      ad_oe_n <= 16'hFFFF;
    end else if ((vec_owner_reg || scr_take || vrt_take) && strobe_on
                 && !no_vector_flag_reg) begin
      ad_out <= {8'h00, vector_reg[7:2], scroll_active_status_reg, vector_reg[0]};
      ad_oe_n <= 16'h0000;
    end else begin
      ad_out <= 16'h0000;
      ad_oe_n <= 16'hFFFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Smooth scroll control and top pointers.

  logic win_selected; // Current window takes part in the scroll.
  logic scroll_here; // Current region is being scrolled.

  assign win_selected = window_scroll_select_reg[window_index];
  // One mode flag picks windows or background, so both can never move together.
  assign scroll_here = scroll_active_status_reg
    && (scroll_window_reg ? (in_window && win_selected) : !in_window);

  // Line address: offset added only where scrolling applies.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      row_line_address <= 5'h00;
    end else begin
      row_line_address <= scroll_here ? row_line_count + scroll_offset_reg
                                      : row_line_count;
    end
  end

  // Scroll status stays until the row in progress finishes after scroll-on drops.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scroll_active_status_reg <= 1'b0;
    end else if (smooth_scroll_on_reg) begin
      scroll_active_status_reg <= 1'b1;
    end else if (row_done) begin
      scroll_active_status_reg <= 1'b0;
    end
  end

  // Direct writes win at once; shadow only moves in at row completion.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      top_hard_reg <= `CIS_RST_TOP;
    end else if (wr_go && avs_address == `CIS_OFF_TOP_HARD) begin
      top_hard_reg <= avs_writedata[15:0];
    end else if (row_done) begin
      top_hard_reg <= top_soft_reg;
    end
  end

  assign active_top = top_hard_reg;

  // Plain configuration registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      block_lower_chain_reg <= 1'b0;
      no_vector_flag_reg <= 1'b0;
      row_count_irq_field_reg <= `CIS_RST_ROWCNT;
      vector_reg <= `CIS_RST_VECTOR;
      smooth_scroll_on_reg <= 1'b0;
      scroll_window_reg <= 1'b0;
      scroll_down_reg <= 1'b0;
      scroll_offset_reg <= 5'h00;
      window_scroll_select_reg <= '0;
      top_soft_reg <= `CIS_RST_TOP;
    end else if (wr_go) begin
      unique case (avs_address)
        `CIS_OFF_MODE2: begin
          block_lower_chain_reg <= avs_writedata[`CIS_M2_BLOCK_LOWER];
          no_vector_flag_reg <= avs_writedata[`CIS_M2_NO_VECTOR];
        end
        `CIS_OFF_VERT: row_count_irq_field_reg <= avs_writedata[7:0];
        `CIS_OFF_VECTOR: vector_reg <= avs_writedata[7:0];
        `CIS_OFF_SCROLL: begin
          smooth_scroll_on_reg <= avs_writedata[`CIS_SC_ON];
          scroll_window_reg <= avs_writedata[`CIS_SC_WINDOW];
          scroll_down_reg <= avs_writedata[`CIS_SC_DOWN];
          scroll_offset_reg <= avs_writedata[`CIS_SC_OFFSET_LSB +: 5];
          window_scroll_select_reg <= avs_writedata[`CIS_SC_WSEL_LSB +: WIN_COUNT];
        end
        `CIS_OFF_TOP_SOFT: top_soft_reg <= avs_writedata[15:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state on every access, answer on the second edge.

  logic [31:0] rd_mux; // Read value for the addressed register.

  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      `CIS_OFF_MODE2: rd_mux = {23'h0, scroll_active_status_reg, no_vector_flag_reg,
        block_lower_chain_reg, vrt_reg.in_service, vrt_reg.enable, vrt_reg.pending,
        scr_reg.in_service, scr_reg.enable, scr_reg.pending};
      `CIS_OFF_VERT: rd_mux = {24'h0, row_count_irq_field_reg};
      // The size cast zero-extends, so a full window count needs no empty padding.
      `CIS_OFF_SCROLL: rd_mux = 32'({window_scroll_select_reg, scroll_offset_reg,
        scroll_down_reg, scroll_window_reg, smooth_scroll_on_reg});
      `CIS_OFF_TOP_SOFT: rd_mux = {16'h0, top_soft_reg};
      `CIS_OFF_TOP_HARD: rd_mux = {16'h0, top_hard_reg};
      `CIS_OFF_VECTOR: rd_mux = {24'h0, vector_reg};
      `CIS_OFF_STATUS: rd_mux = {24'h0, rows_loaded_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Wait request drops for one cycle after a request is taken.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_state_reg <= cis_pkg::CIS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      unique case (bus_state_reg)
        cis_pkg::CIS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_reg <= cis_pkg::CIS_DONE;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
          end
        end
        cis_pkg::CIS_DONE: begin
          bus_state_reg <= cis_pkg::CIS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

endmodule : cis_irq

// ---- sim/cis_host_model.sv ----
`timescale 1ns/1ps
// Host processor side of the acknowledge cycle, with two data strobes per cycle.
module cis_host_model (
  input wire logic clk, // Controller clock.
  input wire logic [15:0] ad_out, // Pin values from the block.
  input wire logic [15:0] ad_oe_n, // Pin enables, low drives.
  output logic ack_n, // Acknowledge strobe, active low.
  output logic ds_n // Data strobe, active low.
);
  logic [15:0] float_pat = 16'hA5A5; // Undriven lines change every cycle, no pull.
  logic [15:0] ad_wire; // Level seen on the pins.
  initial begin
    ack_n = 1'b1;
    ds_n = 1'b1;
  end
  always @(posedge clk) float_pat <= ~float_pat;
  assign ad_wire = (ad_out & ~ad_oe_n) | (float_pat & ad_oe_n);
  // The chain is given four cycles to settle before each strobe falls.
  task automatic ack_cycle(output logic [7:0] vec, output logic drv);
    drv = 1'b1;
    @(posedge clk);
    ack_n <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      repeat (4) @(posedge clk);
      ds_n <= 1'b0;
      repeat (5) @(posedge clk);
      vec = ad_wire[7:0];
      drv = drv && (ad_oe_n === 16'h0000);
      ds_n <= 1'b1;
    end
    @(posedge clk);
    ack_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : ack_cycle
endmodule : cis_host_model

// ---- sim/cis_irq_checker.sv ----
`timescale 1ns/1ps
// Watches the bus handshake, the priority chain, the vector pins and the top pointer.
module cis_irq_checker #(
  parameter int WIN_COUNT = 8 // Window count, handed on for symmetry.
) (
  input wire logic clk, // Controller clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic avs_waitrequest, // Bus stall.
  input wire logic priority_chain_in, // Chain input pin.
  input wire logic priority_chain_out, // Chain output pin.
  input wire logic irq_request_n, // Request line, active low.
  input wire logic irq_acknowledge_strobe_n, // Acknowledge pin, active low.
  input wire logic [15:0] ad_out, // Pin drive values.
  input wire logic [15:0] ad_oe_n, // Pin enables, low drives.
  input wire logic [15:0] active_top // Active top pointer.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Five cycles outlast the two synchroniser flops plus the output flop.
  sequence s_chain_low;
    (!priority_chain_in) [*5];
  endsequence
  sequence s_ack_idle;
    irq_acknowledge_strobe_n [*5];
  endsequence
  sequence s_ack_busy;
    (!irq_acknowledge_strobe_n) [*5];
  endsequence
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest stayed low for two cycles");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered in one cycle");
  vector_form_a: assert property (ad_oe_n != 16'hFFFF |-> ad_oe_n == 16'h0000 && ad_out[15:8] == 8'h00)
    else $error("vector not driven on all pins with upper byte low");
  vector_idle_a: assert property (s_ack_idle |-> ad_oe_n == 16'hFFFF)
    else $error("pins driven outside acknowledge");
  chain_low_a: assert property (s_chain_low |-> !priority_chain_out)
    else $error("chain output high while chain input low");
  req_chain_a: assert property (s_chain_low |=> !$fell(irq_request_n))
    else $error("request raised with chain input low");
  req_ack_a: assert property (s_ack_busy |=> !$fell(irq_request_n))
    else $error("request raised during acknowledge");
  top_write_a: assert property ($changed(active_top) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("top pointer moved without a bus write");
endmodule : cis_irq_checker
bind cis_irq cis_irq_checker #(.WIN_COUNT(WIN_COUNT)) u_chk (
  .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .priority_chain_in(priority_chain_in),
  .priority_chain_out(priority_chain_out), .irq_request_n(irq_request_n),
  .irq_acknowledge_strobe_n(irq_acknowledge_strobe_n), .ad_out(ad_out),
  .ad_oe_n(ad_oe_n), .active_top(active_top));

// ---- sim/crt_irq_daisy_chain_scroll_test.sv ----
`timescale 1ns/1ps
`include "cis_cfg.svh"
module crt_irq_daisy_chain_scroll_test;
  logic clk, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, chain_in = 1'b1; // Bench drives.
  logic in_win = 1'b0, win, drv, chain_out, irq_request_n, avs_waitrequest, ack_n, ds_n;
  logic [5:0] avs_address = 6'h00; // Bus address.
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd; // Bus data.
  logic [15:0] ad_out, ad_oe_n, active_top, top; // Pins and pointer.
  logic [4:0] line_cnt = 5'h00, line_addr, off; // Line count path.
  logic [2:0] win_idx = 3'h0; // Window being shown.
  logic [7:0] vreg, vec, wsel; // Vector and window select.
  int n_mismatch = 0, num_checks = 0, n;
  cis_irq u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .priority_chain_in(chain_in),
    .priority_chain_out(chain_out), .irq_request_n(irq_request_n),
    .irq_acknowledge_strobe_n(ack_n), .data_strobe_n(ds_n), .ad_out(ad_out),
    .ad_oe_n(ad_oe_n), .row_line_count(line_cnt), .in_window(in_win),
    .window_index(win_idx), .row_line_address(line_addr), .active_top(active_top));
  cis_host_model u_host (.clk(clk), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ack_n(ack_n),
    .ds_n(ds_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  // One access; the request holds until waitrequest is seen low at an edge.
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    do begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    chk("bus answer", 32'h0, {31'h0, avs_waitrequest});
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic ev(input int b);
    bus(1'b1, `CIS_OFF_EVENT, 32'h1 << b);
  endtask : ev
  task automatic m2(input logic [8:0] mask, input logic [8:0] e, input string nm);
    bus(1'b0, `CIS_OFF_MODE2, 32'h0);
    chk(nm, {23'h0, e}, {23'h0, rd[8:0] & mask});
  endtask : m2
  // The request line is registered, so a short bounded wait is allowed.
  task automatic req(input logic lvl);
    int t;
    t = 0;
    while (irq_request_n !== lvl && t < 20) begin
      @(posedge clk);
      t++;
    end
    chk("request line", {31'h0, lvl}, {31'h0, irq_request_n});
  endtask : req
  function automatic logic [7:0] exp_vec(input logic [7:0] v, input logic scroll_active_status);
    return {v[7:2], scroll_active_status, v[0]};
  endfunction : exp_vec
  // Background scroll moves non-window characters; window scroll moves selected windows.
  function automatic logic [4:0] exp_line(input logic on, input logic w, input logic [7:0] sel,
      input logic iw, input logic [2:0] ix, input logic [4:0] c, input logic [4:0] o);
    logic moved;
    moved = on && (w ? (iw && sel[ix]) : !iw);
    return moved ? c + o : c;
  endfunction : exp_line
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(32'hC551));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("reset wait", 32'h1, {31'h0, avs_waitrequest});
    chk("reset oe", 32'hFFFF, {16'h0, ad_oe_n});
    bus(1'b0, `CIS_OFF_VERT, 32'h0);
    chk("row count reset", {24'h0, `CIS_RST_ROWCNT}, rd);
    bus(1'b0, 6'h24, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Row count one is the awkward corner, then random counts.
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 1 : 2 + $urandom % 4;
      vreg = $urandom;
      bus(1'b1, `CIS_OFF_VECTOR, {24'h0, vreg});
      bus(1'b1, `CIS_OFF_MODE2, 32'h10);
      bus(1'b1, `CIS_OFF_VERT, n);
      ev(`CIS_EV_FRAME_START);
      repeat (n - 1) ev(`CIS_EV_ROW_LOADED);
      m2(9'h008, 9'h000, "early pending");
      ev(`CIS_EV_ROW_LOADED);
      m2(9'h008, 9'h008, "row pending");
      req(1'b0);
      u_host.ack_cycle(vec, drv);
      chk("vector", {24'h0, exp_vec(vreg, 1'b0)}, {24'h0, vec});
      chk("driven", 32'h1, {31'h0, drv});
      m2(9'h020, 9'h020, "row in service");
      chk("chain blocked", 32'h0, {31'h0, chain_out});
      req(1'b1);
      bus(1'b1, `CIS_OFF_MODE2, 32'h10);
      repeat (4) @(posedge clk);
      chk("chain passes", 32'h1, {31'h0, chain_out});
    end
    $display("row interrupt test done");
    bus(1'b1, `CIS_OFF_SCROLL, 32'h1);
    bus(1'b1, `CIS_OFF_MODE2, 32'h12);
    bus(1'b1, `CIS_OFF_VERT, 32'h1);
    ev(`CIS_EV_FRAME_START);
    ev(`CIS_EV_ROW_LOADED);
    ev(`CIS_EV_ROW_START);
    u_host.ack_cycle(vec, drv);
    chk("scroll vector", {24'h0, exp_vec(vreg, 1'b1)}, {24'h0, vec});
    m2(9'h1FF, 9'h11F, "scroll wins");
    bus(1'b1, `CIS_OFF_MODE2, 32'h9A);
    u_host.ack_cycle(vec, drv);
    chk("no vector", 32'h0, {31'h0, drv});
    m2(9'h025, 9'h020, "row acknowledged");
    $display("priority test done");
    bus(1'b1, `CIS_OFF_MODE2, 32'h0);
    ev(`CIS_EV_ROW_START);
    m2(9'h001, 9'h001, "disabled pending");
    chk("disabled quiet", 32'h1, {31'h0, irq_request_n});
    u_host.ack_cycle(vec, drv);
    chk("ignored pins", 32'h0, {31'h0, drv});
    m2(9'h004, 9'h000, "ignored ack");
    bus(1'b1, `CIS_OFF_MODE2, 32'h3);
    req(1'b0);
    bus(1'b1, `CIS_OFF_MODE2, 32'h1);
    repeat (4) @(posedge clk);
    chk("enable dropped", 32'h1, {31'h0, irq_request_n});
    chain_in <= 1'b0;
    bus(1'b1, `CIS_OFF_MODE2, 32'h3);
    repeat (6) @(posedge clk);
    chk("chain low quiet", 32'h1, {31'h0, irq_request_n});
    chain_in <= 1'b1;
    bus(1'b1, `CIS_OFF_MODE2, 32'h40);
    repeat (6) @(posedge clk);
    chk("block lower", 32'h0, {31'h0, chain_out});
    $display("enable and chain test done");
    bus(1'b1, `CIS_OFF_SCROLL, 32'h0);
    ev(`CIS_EV_ROW_DONE);
    top = $urandom;
    bus(1'b1, `CIS_OFF_TOP_HARD, {16'h0, top});
    bus(1'b1, `CIS_OFF_TOP_SOFT, {16'h0, ~top});
    ev(`CIS_EV_ROW_DONE);
    chk("soft idle", {16'h0, top}, {16'h0, active_top});
    bus(1'b1, `CIS_OFF_SCROLL, 32'h1);
    bus(1'b1, `CIS_OFF_TOP_SOFT, {16'h0, top ^ 16'h5A5A});
    ev(`CIS_EV_ROW_START);
    chk("soft held", {16'h0, top}, {16'h0, active_top});
    ev(`CIS_EV_ROW_DONE);
    repeat (2) @(posedge clk);
    chk("soft moved", {16'h0, top ^ 16'h5A5A}, {16'h0, active_top});
    $display("top pointer test done");
    for (int i = 0; i < 12; i++) begin
      off = $urandom;
      wsel = $urandom;
      win = $urandom;
      bus(1'b1, `CIS_OFF_SCROLL, {16'h0, wsel, off, 1'b0, win, i != 0});
      // Scroll status outlives scroll-on until a row completes, so end it first.
      if (i == 0) ev(`CIS_EV_ROW_DONE);
      line_cnt <= $urandom;
      in_win <= $urandom;
      win_idx <= $urandom;
      repeat (3) @(posedge clk);
      chk("line address", {27'h0, exp_line(i != 0, win, wsel, in_win, win_idx, line_cnt, off)},
        {27'h0, line_addr});
    end
    $display("line offset test done");
    close_out();
  end
endmodule : crt_irq_daisy_chain_scroll_test
